// *** shared/ealu_cfg.svh ***
/*
 * Constants of the execution datapath: status flag positions, reset
 * values, operand masks and cycle counts.
 * Assumes it is included by its bare name after ealu_pkg.
 */
// Operation
// - Register add, optional carry, sets ZCNVH, one cycle
// - Word add immediate on pair, ZCNVS, two cycles
// - Register subtract, optional carry, ZCNVH, one cycle
// - Constant subtract, optional carry, ZCNVH, one cycle
// - Word subtract immediate on pair, ZCNVS, two cycles
// - AND register or constant, ZNV, one cycle
// - OR register or constant, ZNV, one cycle
// - Exclusive OR, test, zero register: ZNV
// - Set mask bits ORs; clear ANDs inverse
// - Pointer jump loads Z, no flags, two cycles
// - Pointer call loads Z, no flags, three cycles
// - Relative jump/call: pc+k+1, two/three cycles
// - Equal compare skips by two or three
// - Compares set ZNVCH, store nothing, one cycle
`ifndef EALU_CFG_SVH
`define EALU_CFG_SVH

`define EALU_FLAG_C      0
`define EALU_FLAG_Z      1
`define EALU_FLAG_N      2
`define EALU_FLAG_V      3
`define EALU_FLAG_S      4
`define EALU_FLAG_H      5
`define EALU_SREG_RESET  8'h00
`define EALU_MASK_ALL    8'hFF
`define EALU_WORD_K_BITS 6
`define EALU_CYC_WORD    3'h2
`define EALU_CYC_JUMP    3'h2
`define EALU_CYC_CALL    3'h3
`define EALU_SKIP_SHORT  16'h0002
`define EALU_SKIP_LONG   16'h0003

`endif

// *** shared/ealu_pkg.sv ***
/*
 * Types of the execution datapath: operation codes, request and
 * response bundles, arithmetic result and the state record.
 * Assumes the decoder hands over operand values already read.
 */
package ealu_pkg;

    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUB,
        OP_SUBTRACT_CONSTANT, OP_SUBTRACT_WITH_CARRY,
        OP_SUBTRACT_CONSTANT_WITH_CARRY, OP_WORD_SUBTRACT_IMMEDIATE,
        OP_AND, OP_AND_CONSTANT, OP_OR, OP_OR_CONSTANT, OP_EXCLUSIVE_OR,
        OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_TEST_ZERO_MINUS,
        OP_ZERO_REGISTER, OP_RELATIVE_JUMP, OP_POINTER_JUMP,
        OP_RELATIVE_CALL, OP_POINTER_CALL, OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_REGISTERS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE
    } ealu_op_t;

    typedef struct packed {
        ealu_op_t    op;
        logic [7:0]  dest;
        logic [7:0]  source_register;
        logic [7:0]  imm;
        logic [15:0] pair;
        logic [15:0] zptr;
        logic [15:0] pc;
        logic [11:0] offset;
        logic        next_two_word;
    } ealu_req_t;

    typedef struct packed {
        logic        ready;
        logic        done;
        logic        reg_we;
        logic [7:0]  reg_data;
        logic        word_we;
        logic [15:0] word_data;
        logic        pc_we;
        logic [15:0] pc_data;
        logic        push_we;
        logic [7:0]  push_data;
    } ealu_rsp_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       h;
        logic       v;
    } ealu_arith_t;

    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} ealu_state_t;

    typedef struct packed {
        ealu_state_t st;
        logic [2:0]  cnt;
        logic        is_call;
        logic        is_word;
        logic        is_pc;
        logic [15:0] word_res;
        logic [7:0]  word_flags;
        logic [15:0] target;
        logic [7:0]  ret_hi;
        logic [7:0]  sreg;
        ealu_rsp_t   rsp;
    } ealu_regs_t;

endpackage : ealu_pkg

// *** hdl/ealu_core.sv ***
/*
 * Execution datapath: 8-bit arithmetic and logic, word add and
 * subtract on register pairs, compares, compare-and-skip, relative
 * and pointer jumps and calls. Holds the status flags itself.
 * Assumes the decoder presents one request with req_valid while
 * rsp.ready is high and writes back what the response strobes say.
 */
`timescale 1ns/100ps
`include "ealu_cfg.svh"

module ealu_core (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              req_valid,
    input  wire ealu_pkg::ealu_req_t req,
    output ealu_pkg::ealu_rsp_t    rsp,
    output logic [7:0]             sreg
);

    ealu_pkg::ealu_regs_t s;
    ealu_pkg::ealu_regs_t next_s;

    // Shared adder for add, subtract and compare; carry out is borrow on subtract
    function automatic ealu_pkg::ealu_arith_t add_sub(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       cin,
        input logic       sub
    );
        ealu_pkg::ealu_arith_t r;
        logic [8:0]            full;
        logic [4:0]            nib;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            r.v  = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            r.v  = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
        end
        r.res = full[7:0];
        r.c   = full[8];
        r.h   = nib[4];
        return r;
    endfunction : add_sub

    // Z C N V H updated, S and the rest kept
    function automatic logic [7:0] arith_flags(
        input logic [7:0]            old,
        input ealu_pkg::ealu_arith_t r
    );
        logic [7:0] f;
        f                = old;
        f[`EALU_FLAG_Z] = (r.res == 8'h00);
        f[`EALU_FLAG_C] = r.c;
        f[`EALU_FLAG_N] = r.res[7];
        f[`EALU_FLAG_V] = r.v;
        f[`EALU_FLAG_H] = r.h;
        return f;
    endfunction : arith_flags

    // Z N V updated, V cleared, carry and half carry kept
    function automatic logic [7:0] logic_flags(
        input logic [7:0] old,
        input logic [7:0] res
    );
        logic [7:0] f;
        f                = old;
        f[`EALU_FLAG_Z] = (res == 8'h00);
        f[`EALU_FLAG_N] = res[7];
        f[`EALU_FLAG_V] = 1'b0;
        return f;
    endfunction : logic_flags

    // Compares share the subtractor but never write the register file
    function automatic logic is_compare(
        input ealu_pkg::ealu_op_t op
    );
        case (op)
            ealu_pkg::OP_COMPARE_REGISTERS,
            ealu_pkg::OP_COMPARE_WITH_CARRY,
            ealu_pkg::OP_COMPARE_IMMEDIATE: return 1'b1;
            default:                        return 1'b0;
        endcase
    endfunction : is_compare

    // Subtract and compare forms whose second operand is the constant
    function automatic logic takes_imm(
        input ealu_pkg::ealu_op_t op
    );
        case (op)
            ealu_pkg::OP_SUBTRACT_CONSTANT,
            ealu_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY,
            ealu_pkg::OP_COMPARE_IMMEDIATE: return 1'b1;
            default:                        return 1'b0;
        endcase
    endfunction : takes_imm

    // Forms that also fold in the stored carry
    function automatic logic takes_carry(
        input ealu_pkg::ealu_op_t op
    );
        case (op)
            ealu_pkg::OP_ADD_CARRY,
            ealu_pkg::OP_SUBTRACT_WITH_CARRY,
            ealu_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY,
            ealu_pkg::OP_COMPARE_WITH_CARRY: return 1'b1;
            default:                         return 1'b0;
        endcase
    endfunction : takes_carry

    // Word results: Z C N V S updated, half carry kept
    function automatic logic [7:0] pair_flags(
        input logic [7:0]  old,
        input logic [15:0] a,
        input logic [16:0] sum,
        input logic        sub
    );
        logic [7:0] f;
        logic       v;
        // Overflow is the pair's sign flipping against the direction of the step
        v                = sub ? (a[15] & ~sum[15]) : (~a[15] & sum[15]);
        f                = old;
        f[`EALU_FLAG_Z] = (sum[15:0] == 16'h0000);
        f[`EALU_FLAG_C] = sum[16];
        f[`EALU_FLAG_N] = sum[15];
        f[`EALU_FLAG_V] = v;
        f[`EALU_FLAG_S] = sum[15] ^ v;
        return f;
    endfunction : pair_flags

    // Wait-state edges of a multi-cycle op, the done edge included
    function automatic logic [2:0] wait_count(
        input ealu_pkg::ealu_op_t op,
        input logic               two_word
    );
        case (op)
            ealu_pkg::OP_WORD_ADD_IMMEDIATE,
            ealu_pkg::OP_WORD_SUBTRACT_IMMEDIATE: return `EALU_CYC_WORD - 3'h1;
            ealu_pkg::OP_RELATIVE_JUMP,
            ealu_pkg::OP_POINTER_JUMP:            return `EALU_CYC_JUMP - 3'h1;
            ealu_pkg::OP_RELATIVE_CALL,
            ealu_pkg::OP_POINTER_CALL:            return `EALU_CYC_CALL - 3'h1;
            ealu_pkg::OP_COMPARE_SKIP_EQUAL:      return two_word ? 3'h2 : 3'h1;
            default:                              return 3'h1;
        endcase
    endfunction : wait_count

    // One path for every bitwise form; test and zero register reuse the register itself
    function automatic logic [7:0] logic_result(
        input ealu_pkg::ealu_op_t op,
        input logic [7:0]         d,
        input logic [7:0]         r,
        input logic [7:0]         k
    );
        case (op)
            ealu_pkg::OP_AND:             return d & r;
            ealu_pkg::OP_AND_CONSTANT:    return d & k;
            ealu_pkg::OP_OR:              return d | r;
            ealu_pkg::OP_OR_CONSTANT:     return d | k;
            ealu_pkg::OP_EXCLUSIVE_OR:    return d ^ r;
            ealu_pkg::OP_SET_MASK_BITS:   return d | k;
            ealu_pkg::OP_CLEAR_MASK_BITS: return d & (`EALU_MASK_ALL - k);
            ealu_pkg::OP_TEST_ZERO_MINUS: return d & d;
            default:                      return d ^ d;
        endcase
    endfunction : logic_result

    always_comb begin
        ealu_pkg::ealu_arith_t ar;
        logic [7:0]            lres;
        logic [16:0]           wsum;
        logic [15:0]           kword;
        logic [15:0]           ret;
        logic [15:0]           rel;
        ar                  = '0;
        lres                = 8'h00;
        wsum                = 17'h00000;
        kword               = {10'h000, req.imm[`EALU_WORD_K_BITS-1:0]};
        ret                 = req.pc + 16'h0001;
        rel                 = req.pc + {{4{req.offset[11]}}, req.offset} + 16'h0001;
        next_s              = s;
        next_s.rsp.done     = 1'b0;
        next_s.rsp.reg_we   = 1'b0;
        next_s.rsp.word_we  = 1'b0;
        next_s.rsp.pc_we    = 1'b0;
        next_s.rsp.push_we  = 1'b0;
        case (s.st)
            ealu_pkg::ST_IDLE: begin
                if (req_valid && s.rsp.ready) begin
                    next_s.is_call = 1'b0;
                    next_s.is_word = 1'b0;
                    next_s.is_pc   = 1'b0;
                    case (req.op)
                        ealu_pkg::OP_ADD, ealu_pkg::OP_ADD_CARRY: begin
                            ar = add_sub(req.dest, req.source_register,
                                takes_carry(req.op) && s.sreg[`EALU_FLAG_C], 1'b0);
                            next_s.rsp.reg_we   = 1'b1;
                            next_s.rsp.reg_data = ar.res;
                            next_s.sreg         = arith_flags(s.sreg, ar);
                            next_s.rsp.done     = 1'b1;
                        end
                        ealu_pkg::OP_SUB, ealu_pkg::OP_SUBTRACT_WITH_CARRY,
                        ealu_pkg::OP_SUBTRACT_CONSTANT, ealu_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY,
                        ealu_pkg::OP_COMPARE_REGISTERS, ealu_pkg::OP_COMPARE_WITH_CARRY,
                        ealu_pkg::OP_COMPARE_IMMEDIATE: begin
                            ar = add_sub(req.dest, takes_imm(req.op) ? req.imm : req.source_register,
                                         takes_carry(req.op) && s.sreg[`EALU_FLAG_C], 1'b1);
                            next_s.rsp.reg_we   = !is_compare(req.op);
                            next_s.rsp.reg_data = ar.res;
                            next_s.sreg         = arith_flags(s.sreg, ar);
                            next_s.rsp.done     = 1'b1;
                        end
                        ealu_pkg::OP_AND, ealu_pkg::OP_AND_CONSTANT, ealu_pkg::OP_OR,
                        ealu_pkg::OP_OR_CONSTANT, ealu_pkg::OP_EXCLUSIVE_OR,
                        ealu_pkg::OP_SET_MASK_BITS, ealu_pkg::OP_CLEAR_MASK_BITS,
                        ealu_pkg::OP_TEST_ZERO_MINUS, ealu_pkg::OP_ZERO_REGISTER: begin
                            lres = logic_result(req.op, req.dest, req.source_register, req.imm);
                            next_s.rsp.reg_we   = 1'b1;
                            next_s.rsp.reg_data = lres;
                            next_s.sreg         = logic_flags(s.sreg, lres);
                            next_s.rsp.done     = 1'b1;
                        end
                        ealu_pkg::OP_WORD_ADD_IMMEDIATE, ealu_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
                            // Result and flags wait for the second cycle
                            if (req.op == ealu_pkg::OP_WORD_ADD_IMMEDIATE) begin
                                wsum = {1'b0, req.pair} + {1'b0, kword};
                            end else begin
                                wsum = {1'b0, req.pair} - {1'b0, kword};
                            end
                            next_s.word_res   = wsum[15:0];
                            next_s.word_flags = pair_flags(s.sreg, req.pair, wsum,
                                                           req.op != ealu_pkg::OP_WORD_ADD_IMMEDIATE);
                            next_s.is_word    = 1'b1;
                            next_s.cnt        = wait_count(req.op, req.next_two_word);
                            next_s.st         = ealu_pkg::ST_WAIT;
                        end
                        ealu_pkg::OP_RELATIVE_JUMP, ealu_pkg::OP_POINTER_JUMP: begin
                            next_s.target = (req.op == ealu_pkg::OP_POINTER_JUMP) ? req.zptr : rel;
                            next_s.is_pc  = 1'b1;
                            next_s.cnt    = wait_count(req.op, req.next_two_word);
                            next_s.st     = ealu_pkg::ST_WAIT;
                        end
                        ealu_pkg::OP_RELATIVE_CALL, ealu_pkg::OP_POINTER_CALL: begin
                            next_s.target        = (req.op == ealu_pkg::OP_POINTER_CALL) ? req.zptr : rel;
                            next_s.rsp.push_we   = 1'b1;
                            next_s.rsp.push_data = ret[7:0];
                            next_s.ret_hi        = ret[15:8];
                            next_s.is_pc         = 1'b1;
                            next_s.is_call       = 1'b1;
                            next_s.cnt           = wait_count(req.op, req.next_two_word);
                            next_s.st            = ealu_pkg::ST_WAIT;
                        end
                        ealu_pkg::OP_COMPARE_SKIP_EQUAL: begin
                            if (req.dest == req.source_register) begin
                                next_s.target = req.pc + (req.next_two_word ? `EALU_SKIP_LONG
                                                                            : `EALU_SKIP_SHORT);
                                next_s.is_pc  = 1'b1;
                                next_s.cnt    = wait_count(req.op, req.next_two_word);
                                next_s.st     = ealu_pkg::ST_WAIT;
                            end else begin
                                next_s.rsp.done = 1'b1;
                            end
                        end
                        default: begin
                            next_s.rsp.done = 1'b1;
                        end
                    endcase
                end
            end
            ealu_pkg::ST_WAIT: begin
                next_s.cnt = s.cnt - 3'h1;
                if (s.is_call && s.cnt == 3'h2) begin
                    // High byte goes out before the pc changes
                    next_s.rsp.push_we   = 1'b1;
                    next_s.rsp.push_data = s.ret_hi;
                end
                if (s.cnt == 3'h1) begin
                    next_s.st            = ealu_pkg::ST_IDLE;
                    next_s.rsp.done      = 1'b1;
                    next_s.rsp.word_we   = s.is_word;
                    next_s.rsp.word_data = s.word_res;
                    next_s.rsp.pc_we     = s.is_pc;
                    next_s.rsp.pc_data   = s.target;
                    if (s.is_word) begin
                        next_s.sreg = s.word_flags;
                    end
                end
            end
            default: begin
                next_s.st = ealu_pkg::ST_IDLE;
            end
        endcase
        next_s.rsp.ready = (next_s.st == ealu_pkg::ST_IDLE);
    end

    // Reset does not wait for ce, so a stalled core still comes up idle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s      <= '0;
            s.sreg <= `EALU_SREG_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Strobes stretch while ce is low; the far side counts them on ce-high edges only
    assign rsp  = s.rsp;
    assign sreg = s.sreg;

endmodule : ealu_core

// *** verification/ealu_chk.sv ***
/* Port checker of the execution datapath.
   Assumes it is bound to ealu_core; checks pause while ce is low. */
`timescale 1ns/100ps
module ealu_chk (
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic                ce,
    input wire logic                req_valid,
    input wire ealu_pkg::ealu_req_t req,
    input wire ealu_pkg::ealu_rsp_t rsp,
    input wire logic [7:0]          sreg
);
    ealu_pkg::ealu_req_t q;
    logic [7:0]          s_d;
    logic                tk;
    assign tk = req_valid && rsp.ready;
    // Keeps the taken request, since req may change while busy
    always_ff @(posedge clk) begin
        s_d <= sreg;
        if (tk)
            q <= req;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b || !ce);

    property p_add;
        tk && req.op == ealu_pkg::OP_ADD |=> rsp.done && rsp.reg_we && rsp.reg_data == q.dest + q.source_register;
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_word_add;
        tk && req.op == ealu_pkg::OP_WORD_ADD_IMMEDIATE |=> !rsp.ready ##1 rsp.done && rsp.word_data == q.pair + q.imm[5:0];
    endproperty
    a_word_add: assert property (p_word_add) else $error("word add wrong");
    property p_logic;
        tk && req.op inside {[ealu_pkg::OP_AND:ealu_pkg::OP_ZERO_REGISTER]} |=> !sreg[3] && sreg[0] == s_d[0] && sreg[5:4] == s_d[5:4];
    endproperty
    a_logic: assert property (p_logic) else $error("logic flags wrong");
    property p_ptr_jump;
        tk && req.op == ealu_pkg::OP_POINTER_JUMP |=> !rsp.done ##1 rsp.pc_we && rsp.pc_data == q.zptr && sreg == s_d;
    endproperty
    a_ptr_jump: assert property (p_ptr_jump) else $error("pointer jump wrong");
    property p_ptr_call;
        tk && req.op == ealu_pkg::OP_POINTER_CALL |=> rsp.push_we && !rsp.pc_we ##1 rsp.push_we ##1 rsp.pc_data == q.zptr;
    endproperty
    a_ptr_call: assert property (p_ptr_call) else $error("pointer call wrong");
    property p_rel_jump;
        tk && req.op == ealu_pkg::OP_RELATIVE_JUMP |=> !rsp.pc_we ##1 rsp.pc_we && rsp.pc_data == q.pc + {{4{q.offset[11]}}, q.offset} + 16'h0001;
    endproperty
    a_rel_jump: assert property (p_rel_jump) else $error("relative jump wrong");
    property p_skip;
        tk && req.op == ealu_pkg::OP_COMPARE_SKIP_EQUAL && req.dest != req.source_register |=> rsp.done && !rsp.pc_we && sreg == s_d;
    endproperty
    a_skip: assert property (p_skip) else $error("unequal skip wrong");
    property p_cmp;
        tk && req.op inside {[ealu_pkg::OP_COMPARE_REGISTERS:ealu_pkg::OP_COMPARE_IMMEDIATE]} |=> rsp.done && !rsp.reg_we;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare stored");
endmodule : ealu_chk

bind ealu_core ealu_chk u_chk (.clk(clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid), .req(req), .rsp(rsp),
    .sreg(sreg));

// *** verification/ealu_rf_model.sv ***
/* Register file side: keeps the bytes that calls push onto the stack.
   Assumes a push strobe counts once per clock edge with ce high. */
`timescale 1ns/100ps
module ealu_rf_model (
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic                ce,
    input wire ealu_pkg::ealu_rsp_t rsp
);
    logic [7:0] stack [$];
    always @(posedge clk) begin
        if (rst_b && ce && rsp.push_we)
            stack.push_back(rsp.push_data);
    end
endmodule : ealu_rf_model

// *** verification/ealu_core_tb.sv ***
/* Self-checking bench: every operation except OP_NOP with random operands, checked
   against an integer model. Assumes the checker and stack model compile first. */
`timescale 1ns/100ps
module ealu_core_tb;
    logic                clk = 1'b0;
    logic                rst_b;
    logic                ce;
    logic                req_valid;
    ealu_pkg::ealu_req_t req;
    ealu_pkg::ealu_rsp_t rsp;
    logic [7:0]          sreg;
    ealu_pkg::ealu_req_t r;
    int                  n_fail = 0;
    int                  n_checks = 0;
    int                  cyc = 0;
    int                  ms, res, kind, cy;

    ealu_core dut (.clk(clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid), .req(req), .rsp(rsp), .sreg(sreg));
    ealu_rf_model u_rf (.clk(clk), .rst_b(rst_b), .ce(ce), .rsp(rsp));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        // The sweep needs under 2500 cycles
        if (cyc == 10000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic arith(input int a, input int b, input int c, input int s);
        int x, v, h;
        x = s ? a - b - c : a + b + c;
        res = x & 255;
        v = ((a ^ b ^ (s ? 0 : 128)) & 128) != 0 && ((a ^ res) & 128) != 0;
        h = s ? (a & 15) < (b & 15) + c : (a & 15) + (b & 15) + c > 15;
        ms = (ms & 'hD0) | (x < 0 || x > 255) | (res == 0) << 1 | (res >> 7) << 2 | v << 3 | h << 5;
    endtask : arith

    task automatic word(input int a, input int k, input int s);
        int x, n, v;
        x = s ? a - k : a + k;
        res = x & 65535;
        n = res >> 15;
        v = s ? a >> 15 && !n : !(a >> 15) && n;
        ms = (ms & 'hE0) | (x < 0 || x > 65535) | (res == 0) << 1 | n << 2 | v << 3 | (n ^ v) << 4;
        kind = 2;
        cy = 2;
    endtask : word

    task automatic lg(input int x);
        res = x & 255;
        ms = (ms & 'hF1) | (res == 0) << 1 | (res >> 7) << 2;
    endtask : lg

    task automatic ctl(input int p, input int c);
        res = p & 65535;
        cy = c;
        kind = 3;
    endtask : ctl

    task automatic do_op(input ealu_pkg::ealu_req_t q);
        int a, b, k, n;
        a = q.dest;
        b = q.source_register;
        k = $signed(q.offset);
        cy = 1;
        kind = q.op inside {[ealu_pkg::OP_COMPARE_REGISTERS:ealu_pkg::OP_COMPARE_IMMEDIATE]} ? 0 : 1;
        case (q.op)
            ealu_pkg::OP_ADD: arith(a, b, 0, 0);
            ealu_pkg::OP_ADD_CARRY: arith(a, b, ms & 1, 0);
            ealu_pkg::OP_SUB, ealu_pkg::OP_COMPARE_REGISTERS: arith(a, b, 0, 1);
            ealu_pkg::OP_SUBTRACT_CONSTANT, ealu_pkg::OP_COMPARE_IMMEDIATE: arith(a, q.imm, 0, 1);
            ealu_pkg::OP_SUBTRACT_WITH_CARRY, ealu_pkg::OP_COMPARE_WITH_CARRY: arith(a, b, ms & 1, 1);
            ealu_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY: arith(a, q.imm, ms & 1, 1);
            ealu_pkg::OP_WORD_ADD_IMMEDIATE: word(q.pair, q.imm & 63, 0);
            ealu_pkg::OP_WORD_SUBTRACT_IMMEDIATE: word(q.pair, q.imm & 63, 1);
            ealu_pkg::OP_AND: lg(a & b);
            ealu_pkg::OP_AND_CONSTANT: lg(a & q.imm);
            ealu_pkg::OP_OR: lg(a | b);
            ealu_pkg::OP_OR_CONSTANT, ealu_pkg::OP_SET_MASK_BITS: lg(a | q.imm);
            ealu_pkg::OP_EXCLUSIVE_OR: lg(a ^ b);
            ealu_pkg::OP_CLEAR_MASK_BITS: lg(a & (255 - q.imm));
            ealu_pkg::OP_ZERO_REGISTER: lg(a ^ a);
            ealu_pkg::OP_TEST_ZERO_MINUS: lg(a & a);
            ealu_pkg::OP_RELATIVE_JUMP: ctl(q.pc + k + 1, 2);
            ealu_pkg::OP_RELATIVE_CALL: ctl(q.pc + k + 1, 3);
            ealu_pkg::OP_POINTER_JUMP: ctl(q.zptr, 2);
            ealu_pkg::OP_POINTER_CALL: ctl(q.zptr, 3);
            ealu_pkg::OP_COMPARE_SKIP_EQUAL:
                if (a == b)
                    ctl(q.pc + 2 + q.next_two_word, 2 + q.next_two_word);
                else
                    kind = 0;
            default: kind = 0;
        endcase
        req = q;
        req_valid = 1'b1;
        @(posedge clk);
        n = 1;
        @(negedge clk);
        while (rsp.done !== 1'b1 && n < 5) begin
            // Requests while busy must be ignored; a low ce must only stretch the op
            req.dest = ~req.dest;
            ce = ($urandom % 4) != 0;
            @(posedge clk);
            n += ce;
            @(negedge clk);
        end
        check("cycles", 16'(n), 16'(cy));
        if (kind >= 0)
            check("strobes", {13'h0, rsp.reg_we, rsp.word_we, rsp.pc_we}, 16'((8 >> kind) & 7));
        if (kind == 1)
            check("byte", {8'h00, rsp.reg_data}, 16'(res));
        if (kind == 2)
            check("word", rsp.word_data, 16'(res));
        if (kind == 3)
            check("pc", rsp.pc_data, 16'(res));
        if (q.op inside {ealu_pkg::OP_RELATIVE_CALL, ealu_pkg::OP_POINTER_CALL}) begin
            check("return", {u_rf.stack[1], u_rf.stack[0]}, q.pc + 16'h0001);
            u_rf.stack.delete();
        end
        check("flags", {8'h00, sreg}, 16'(ms));
    endtask : do_op

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        ms = 0;
        void'($urandom(84419));
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("reset flags", {8'h00, sreg}, 16'h0000);
        rst_b = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 30; i++) begin
            for (int o = 1; o < 26; o++) begin
                r = 90'({$urandom, $urandom, $urandom});
                r.op = ealu_pkg::ealu_op_t'(o);
                if (i % 4 == 0)
                    r.source_register = r.dest;
                if (i == 1) begin
                    r.dest = 8'hFF;
                    r.source_register = 8'h01;
                    r.pair = 16'hFFFF;
                end
                do_op(r);
            end
        end
        end_sim();
    end
endmodule : ealu_core_tb
